// File: common/amp_rail_pkg.sv
// Constants for the amplifier supply-rail and idle-mode controller.
// Assumes a single 25 MHz clock domain and an APB register slave.
`default_nettype none
package amp_rail_pkg;
    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] THRESH_OFS   = 8'h04;
    localparam logic [7:0] TIMING_OFS   = 8'h08;
    localparam logic [7:0] IDLE_OFS     = 8'h0c;
    localparam logic [7:0] STATUS_OFS   = 8'h10;
    // Control register fields.
    localparam int CTRL_EN_BIT          = 0;
    localparam int CTRL_SEL_LSB         = 1;
    localparam int CTRL_METH_LSB        = 3;
    localparam int CTRL_SINGLE_BIT      = 5;
    localparam int CTRL_IDLE_EN_BIT     = 6;
    localparam int CTRL_WSZ_LSB         = 7;
    // Reset values.
    localparam logic [31:0] CTRL_RST    = 32'h0000_0008;
    localparam logic [31:0] THRESH_RST  = 32'h0000_0000;
    localparam logic [31:0] TIMING_RST  = 32'h0000_0000;
    localparam logic [31:0] IDLE_RST    = 32'h0000_0000;
    // Supply selection and threshold method codes.
    localparam logic [1:0] SEL_DUAL     = 2'h0;
    localparam logic [1:0] SEL_HIGH     = 2'h1;
    localparam logic [1:0] SEL_LOW      = 2'h2;
    localparam logic [1:0] METH_FIXED   = 2'h0;
    localparam logic [1:0] METH_HEAD    = 2'h1;
    localparam logic [1:0] METH_MIN     = 2'h2;
    // Word size codes: 16, 24 or 32 bit slots.
    localparam logic [1:0] WSZ_16       = 2'h0;
    localparam logic [1:0] WSZ_24       = 2'h1;
    // Idle entry sample count.
    localparam int IDLE_COUNT           = 1024;
    typedef enum logic [1:0] {
        RAIL_HIGH = 2'b00,
        RAIL_WAIT = 2'b01,
        RAIL_ZC   = 2'b10,
        RAIL_LOW  = 2'b11
    } rail_state_e;
endpackage
`default_nettype wire

// File: hdl/amp_supply_rail_ctrl.sv
// Supply-rail selection, signal-path delay and idle-mode control.
// Assumes samples, rail measurements and APB share i_clock.
`default_nettype none
module amp_supply_rail_ctrl #(
    parameter int LVL_W   = 12,
    parameter int DLY_MAX = 15
) (
    input  wire logic              i_clock,
    input  wire logic              i_rstn,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [7:0]        i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    input  wire logic [LVL_W-1:0]  i_low_rail_level,
    input  wire logic              i_sample_valid,
    input  wire logic [31:0]       i_sample,
    input  wire logic [15:0]       i_isense,
    input  wire logic [15:0]       i_vsense,
    output logic                   o_sample_valid,
    output logic      [31:0]       o_sample,
    output logic      [15:0]       o_isense,
    output logic      [15:0]       o_vsense,
    output logic                   o_low_rail_active_out,
    output logic                   o_idle
);
    // Refuses at elaboration the widths that the register fields and the delay line cannot hold.
    if (LVL_W < 4 || LVL_W > 16 || DLY_MAX < 1 || DLY_MAX > 15)
    begin
        $error("amp_supply_rail_ctrl: unsupported parameters");
    end

    //------------------------------------------------------------------
    // Register slave
    //------------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] thresh_q;
    logic [31:0] timing_q;
    logic [31:0] idle_q;
    wire         wr_en   = i_psel & i_penable & i_pwrite;
    wire         hit_ctl = (i_paddr == amp_rail_pkg::CTRL_OFS);
    wire         hit_thr = (i_paddr == amp_rail_pkg::THRESH_OFS);
    wire         hit_tim = (i_paddr == amp_rail_pkg::TIMING_OFS);
    wire         hit_idl = (i_paddr == amp_rail_pkg::IDLE_OFS);
    wire         hit_sts = (i_paddr == amp_rail_pkg::STATUS_OFS);
    wire         mapped  = hit_ctl | hit_thr | hit_tim | hit_idl | hit_sts;

    // Zero-wait slave; unmapped addresses answer with an error.
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~mapped;

    // Configuration fields decoded from the registers.
    wire             path_on       = ctrl_q[amp_rail_pkg::CTRL_EN_BIT];
    wire [1:0]       supply_sel    = ctrl_q[amp_rail_pkg::CTRL_SEL_LSB +: 2];
    wire [1:0]       method        = ctrl_q[amp_rail_pkg::CTRL_METH_LSB +: 2];
    wire             single_supply = ctrl_q[amp_rail_pkg::CTRL_SINGLE_BIT];
    wire             idle_en       = ctrl_q[amp_rail_pkg::CTRL_IDLE_EN_BIT];
    wire [1:0]       word_size     = ctrl_q[amp_rail_pkg::CTRL_WSZ_LSB +: 2];
    wire [LVL_W-1:0] fixed_thr     = thresh_q[0 +: LVL_W];
    wire [LVL_W-1:0] headroom      = thresh_q[16 +: LVL_W];
    wire [LVL_W-1:0] min_level     = timing_q[16 +: LVL_W];
    wire [11:0]      hold_cnt      = timing_q[11:0];
    wire [3:0]       sw_delay      = timing_q[15:12];
    wire [4:0]       entry_bits    = idle_q[4:0];
    wire [4:0]       exit_bits     = idle_q[12:8];

    // Writes store the addressed register; STATUS ignores them.
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ctrl_q   <= amp_rail_pkg::CTRL_RST;
            thresh_q <= amp_rail_pkg::THRESH_RST;
            timing_q <= amp_rail_pkg::TIMING_RST;
            idle_q   <= amp_rail_pkg::IDLE_RST;
        end
        else if (wr_en)
        begin
            if (hit_ctl) ctrl_q   <= {23'h0, i_pwdata[8:0]};
            if (hit_thr) thresh_q <= i_pwdata;
            if (hit_tim) timing_q <= i_pwdata;
            if (hit_idl) idle_q   <= {19'h0, i_pwdata[12:8], 3'h0, i_pwdata[4:0]};
        end
    end

    //------------------------------------------------------------------
    // Mode and threshold selection
    //------------------------------------------------------------------
    wire mode_high = single_supply | (supply_sel == amp_rail_pkg::SEL_HIGH);
    wire mode_low  = ~mode_high & (supply_sel == amp_rail_pkg::SEL_LOW);
    wire mode_dual = ~mode_high & ~mode_low;

    // Headroom threshold saturates at zero rather than wrapping.
    wire [LVL_W-1:0] head_thr = (i_low_rail_level > headroom) ?
                                (i_low_rail_level - headroom) : '0;
    wire [LVL_W-1:0] min_thr  = (fixed_thr < head_thr) ? fixed_thr : head_thr;
    wire [LVL_W-1:0] rail_switch_level =
        (method == amp_rail_pkg::METH_FIXED) ? fixed_thr :
        (method == amp_rail_pkg::METH_MIN)   ? min_thr : head_thr;
    wire low_rail_weak = i_low_rail_level < min_level;

    //------------------------------------------------------------------
    // Sample alignment and magnitude
    //------------------------------------------------------------------
    // Slot is MSB-justified; the word size decides where the LSB sits.
    logic [31:0] aligned;
    always_comb
    begin
        case (word_size)
            amp_rail_pkg::WSZ_16: aligned = {{16{i_sample[31]}}, i_sample[31:16]};
            amp_rail_pkg::WSZ_24: aligned = {{8{i_sample[31]}}, i_sample[31:8]};
            default:              aligned = i_sample;
        endcase
    end
    wire [31:0] magnitude = aligned[31] ? (~aligned + 32'h1) : aligned;

    // Count of active bits: position of the highest set bit plus one.
    logic [5:0] active_bits;
    always_comb
    begin
        active_bits = 6'h0;
        for (int k = 0; k < 32; k++)
            if (magnitude[k]) active_bits = 6'(k + 1);
    end
    wire above_entry = active_bits > {1'b0, entry_bits};
    wire above_exit  = active_bits > {1'b0, exit_bits};

    // Signal level compared in the threshold's units (top of magnitude).
    wire [LVL_W-1:0] sig_level = magnitude[30 -: LVL_W];
    wire             sig_above = sig_level > rail_switch_level;
    logic            prev_sign_q;
    wire             zero_cross = i_sample_valid & (aligned[31] != prev_sign_q);

    //------------------------------------------------------------------
    // Rail state machine
    //------------------------------------------------------------------
    amp_rail_pkg::rail_state_e state_q;
    amp_rail_pkg::rail_state_e state_d;
    logic [11:0] hold_q;
    wire         hold_done = hold_q > hold_cnt;
    wire         force_hi  = ~path_on | low_rail_weak | (i_sample_valid & sig_above);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            amp_rail_pkg::RAIL_HIGH: state_d = force_hi ? amp_rail_pkg::RAIL_HIGH
                                                        : amp_rail_pkg::RAIL_WAIT;
            amp_rail_pkg::RAIL_WAIT:
                if (force_hi) state_d = amp_rail_pkg::RAIL_HIGH;
                else if (hold_done) state_d = amp_rail_pkg::RAIL_ZC;
            amp_rail_pkg::RAIL_ZC:
                if (force_hi) state_d = amp_rail_pkg::RAIL_HIGH;
                else if (zero_cross) state_d = amp_rail_pkg::RAIL_LOW;
            amp_rail_pkg::RAIL_LOW:
                if (force_hi) state_d = amp_rail_pkg::RAIL_HIGH;
            default: state_d = amp_rail_pkg::RAIL_HIGH;
        endcase
        if (!mode_dual) state_d = amp_rail_pkg::RAIL_HIGH;
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_q     <= amp_rail_pkg::RAIL_HIGH;
            hold_q      <= 12'h0;
            prev_sign_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            hold_q  <= (state_d == amp_rail_pkg::RAIL_WAIT && hold_q != 12'hfff) ?
                       hold_q + 12'h1 : 12'h0;
            if (i_sample_valid) prev_sign_q <= aligned[31];
        end
    end

    // Low-rail flag: fixed low, or dual rail settled on the low rail.
    logic low_active_q;
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn) low_active_q <= 1'b0;
        else low_active_q <= path_on & (mode_low |
                             (mode_dual & state_d == amp_rail_pkg::RAIL_LOW));
    end
    assign o_low_rail_active_out = low_active_q;

    //------------------------------------------------------------------
    // Signal-path delay line
    //------------------------------------------------------------------
    logic [31:0] dly_q [DLY_MAX+1];
    logic [DLY_MAX:0] dvld_q;
    wire  [3:0] tap = mode_dual ? sw_delay : 4'h0;
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            dvld_q <= '0;
            for (int k = 0; k <= DLY_MAX; k++) dly_q[k] <= 32'h0;
        end
        else
        begin
            dvld_q <= {dvld_q[DLY_MAX-1:0], i_sample_valid & path_on};
            dly_q[0] <= i_sample;
            for (int k = 1; k <= DLY_MAX; k++) dly_q[k] <= dly_q[k-1];
        end
    end
    wire [3:0] tap_c = (tap > 4'(DLY_MAX)) ? 4'(DLY_MAX) : tap;
    assign o_sample_valid = dvld_q[tap_c];
    assign o_sample       = path_on ? dly_q[tap_c] : 32'h0;

    //------------------------------------------------------------------
    // Idle detector
    //------------------------------------------------------------------
    logic [10:0] quiet_q;
    logic        idle_q_r;
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            quiet_q  <= 11'h0;
            idle_q_r <= 1'b0;
        end
        else if (!idle_en || !path_on)
        begin
            quiet_q  <= 11'h0;
            idle_q_r <= 1'b0;
        end
        else if (i_sample_valid)
        begin
            if (above_entry) quiet_q <= 11'h0;
            else if (quiet_q != 11'h7ff) quiet_q <= quiet_q + 11'h1;
            if (idle_q_r && above_exit) idle_q_r <= 1'b0;
            else if (!above_entry && quiet_q >= 11'(amp_rail_pkg::IDLE_COUNT))
                idle_q_r <= 1'b1;
        end
    end
    assign o_idle = idle_q_r;

    // Sense results are zeroed while idle.
    logic [15:0] isense_q;
    logic [15:0] vsense_q;
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            isense_q <= 16'h0;
            vsense_q <= 16'h0;
        end
        else
        begin
            isense_q <= idle_q_r ? 16'h0 : i_isense;
            vsense_q <= idle_q_r ? 16'h0 : i_vsense;
        end
    end
    assign o_isense = isense_q;
    assign o_vsense = vsense_q;

    // Read mux; status shows rail state and idle.
    wire [31:0] status = {26'h0, idle_q_r, low_active_q, 2'h0, state_q};
    assign o_prdata = hit_ctl ? ctrl_q : hit_thr ? thresh_q : hit_tim ? timing_q :
                      hit_idl ? idle_q : hit_sts ? status : 32'h0;

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    property p_fixed_high;
        @(posedge i_clock) disable iff (!i_rstn)
        mode_high |=> !o_low_rail_active_out;
    endproperty
    a_fixed_high: assert property (p_fixed_high) else $error("low rail in high mode");

    property p_fixed_low;
        @(posedge i_clock) disable iff (!i_rstn)
        (mode_low && path_on) |=> o_low_rail_active_out;
    endproperty
    a_fixed_low: assert property (p_fixed_low) else $error("low rail missing");

    property p_prompt_high;
        @(posedge i_clock) disable iff (!i_rstn)
        (mode_dual && i_sample_valid && sig_above) |=> !o_low_rail_active_out;
    endproperty
    a_prompt_high: assert property (p_prompt_high) else $error("slow rail rise");

    property p_weak_low;
        @(posedge i_clock) disable iff (!i_rstn)
        low_rail_weak |=> state_q == amp_rail_pkg::RAIL_HIGH;
    endproperty
    a_weak_low: assert property (p_weak_low) else $error("weak low rail used");

    property p_zc_gate;
        @(posedge i_clock) disable iff (!i_rstn)
        ($rose(state_q == amp_rail_pkg::RAIL_LOW)) |-> $past(zero_cross);
    endproperty
    a_zc_gate: assert property (p_zc_gate) else $error("low rail without zero cross");

    property p_idle_zero;
        @(posedge i_clock) disable iff (!i_rstn)
        o_idle |=> (o_isense == 16'h0 && o_vsense == 16'h0);
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("sense not zero");

    property p_idle_exit;
        @(posedge i_clock) disable iff (!i_rstn)
        (o_idle && i_sample_valid && above_exit && idle_en && path_on) |=> !o_idle;
    endproperty
    a_idle_exit: assert property (p_idle_exit) else $error("idle kept");

    property p_idle_entry;
        @(posedge i_clock) disable iff (!i_rstn)
        $rose(o_idle) |-> $past(quiet_q) >= 11'(amp_rail_pkg::IDLE_COUNT);
    endproperty
    a_idle_entry: assert property (p_idle_entry) else $error("early idle");

    property p_path_off;
        @(posedge i_clock) disable iff (!i_rstn)
        !path_on |-> o_sample == 32'h0;
    endproperty
    a_path_off: assert property (p_path_off) else $error("path not gated");

    // The single-supply flag wins over a low-rail selection.
    property p_single_high;
        @(posedge i_clock) disable iff (!i_rstn)
        single_supply |=> !o_low_rail_active_out;
    endproperty
    a_single_high: assert property (p_single_high) else $error("single low");

    // The flag only stands for fixed low mode or a dual-rail low state.
    property p_low_source;
        @(posedge i_clock) disable iff (!i_rstn)
        o_low_rail_active_out |-> ($past(mode_low) || state_q == amp_rail_pkg::RAIL_LOW);
    endproperty
    a_low_source: assert property (p_low_source) else $error("low flag unsourced");

    // Waiting for a zero crossing starts only once the hold has run out.
    property p_hold_gate;
        @(posedge i_clock) disable iff (!i_rstn)
        $rose(state_q == amp_rail_pkg::RAIL_ZC) |-> $past(hold_done);
    endproperty
    a_hold_gate: assert property (p_hold_gate) else $error("early zero-cross wait");

    c_weak_rail: cover property (@(posedge i_clock) disable iff (!i_rstn)
        mode_dual && low_rail_weak);

    c_low_rail: cover property (@(posedge i_clock) disable iff (!i_rstn)
        mode_dual && $rose(o_low_rail_active_out));
    c_idle_in: cover property (@(posedge i_clock) disable iff (!i_rstn) $rose(o_idle));
    c_idle_out: cover property (@(posedge i_clock) disable iff (!i_rstn) $fell(o_idle));
endmodule
`default_nettype wire

// File: test/pcm_source_model.sv
// Audio sample source standing in for the serial audio receiver.
// Assumes requests arrive by non-blocking assignment just after the clock edge.
`default_nettype none
module pcm_source_model (
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    input  wire logic        i_send,
    input  wire logic [31:0] i_word,
    output logic             o_valid,
    output logic      [31:0] o_word
);
    timeunit 1ns;
    timeprecision 1ps;
    // Emits one-cycle sample pulses; between samples the data bus flips so stale data never helps.
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_valid <= 1'b0;
            o_word  <= 32'h0000_0000;
        end
        else
        begin
            o_valid <= i_send;
            o_word  <= i_send ? i_word : ~o_word;
        end
    end
endmodule
`default_nettype wire

// File: test/amp_supply_rail_ctrl_tb.sv
// Self-checking bench for the supply-rail and idle controller.
// Assumes zero-wait APB answers and one 25 MHz clock for all traffic.
`default_nettype none
module amp_supply_rail_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        i_clock     = 1'b0;
    logic        i_rstn      = 1'b0;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [7:0]  paddr       = 8'h00;
    logic [31:0] pwdata      = 32'h0;
    logic [11:0] level       = 12'h300;
    logic        send        = 1'b0;
    logic [31:0] word        = 32'h0;
    logic [31:0] prdata, s_word, o_word, rd;
    logic [15:0] o_isense, o_vsense;
    logic        pready, pslverr, s_valid, o_valid, low_out, idle, err;
    int          miscompares = 0;
    int          tests_run   = 0;
    int          cycles      = 0;
    int          n;

    // Design and the sample source feeding it.
    amp_supply_rail_ctrl #(.LVL_W(12), .DLY_MAX(15)) i_amp_supply_rail_ctrl (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_low_rail_level(level),
        .i_sample_valid(s_valid), .i_sample(s_word), .i_isense(16'h1234),
        .i_vsense(16'h4321), .o_sample_valid(o_valid), .o_sample(o_word),
        .o_isense(o_isense), .o_vsense(o_vsense), .o_low_rail_active_out(low_out),
        .o_idle(idle));
    pcm_source_model i_pcm_source_model (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_send(send), .i_word(word),
        .o_valid(s_valid), .o_word(s_word));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // One APB transfer; the request holds until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        @(posedge i_clock);
        while (pready !== 1'b1)
            @(posedge i_clock);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic send_word(input logic [31:0] w);
        @(posedge i_clock);
        send <= 1'b1;
        word <= w;
        @(posedge i_clock);
        send <= 1'b0;
    endtask

    task automatic settle;
        repeat (4) @(posedge i_clock);
        #1;
    endtask

    // A loud sample parks the rail high, then k quiet samples follow.
    task automatic rail_trial(input logic [31:0] c, input logic [31:0] t, input int k,
                              input logic alt);
        apb(1'b1, amp_rail_pkg::CTRL_OFS, c);
        apb(1'b1, amp_rail_pkg::TIMING_OFS, t);
        send_word(32'h4000_0000);
        for (int i = 0; i < k; i++)
            send_word((alt && i[0]) ? 32'hf400_0000 : 32'h0c00_0000);
        settle;
    endtask

    // Counts cycles from the taking edge until the sample reappears, giving up at 10.
    task automatic latency;
        send_word(32'h0c00_0000);
        @(posedge i_clock);
        #1;
        n = 0;
        while (o_valid !== 1'b1 && n < 10)
        begin
            @(posedge i_clock);
            #1;
            n++;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        apb(1'b0, amp_rail_pkg::CTRL_OFS, 32'h0);
        chk("ctrl reset", rd, amp_rail_pkg::CTRL_RST);
        apb(1'b0, amp_rail_pkg::TIMING_OFS, 32'h0);
        chk("timing reset", rd, amp_rail_pkg::TIMING_RST);
        apb(1'b0, amp_rail_pkg::IDLE_OFS, 32'h0);
        chk("idle reset", rd, amp_rail_pkg::IDLE_RST);
        apb(1'b1, amp_rail_pkg::THRESH_OFS, 32'h0100_0100);
        apb(1'b0, amp_rail_pkg::THRESH_OFS, 32'h0);
        chk("thresh rw", rd, 32'h0100_0100);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
    endtask

    task automatic t_fixed;
        apb(1'b1, amp_rail_pkg::CTRL_OFS, 32'h0000_000b);
        send_word(32'h0c00_0000);
        settle;
        chk("fixed high", {31'h0, low_out}, 32'h0);
        apb(1'b1, amp_rail_pkg::CTRL_OFS, 32'h0000_000d);
        send_word(32'h4000_0000);
        settle;
        chk("fixed low", {31'h0, low_out}, 32'h1);
        apb(1'b0, amp_rail_pkg::STATUS_OFS, 32'h0);
        chk("status low", {31'h0, rd[4]}, 32'h1);
        apb(1'b1, amp_rail_pkg::CTRL_OFS, 32'h0000_002d);
        settle;
        chk("single supply", {31'h0, low_out}, 32'h0);
        apb(1'b1, amp_rail_pkg::CTRL_OFS, 32'h0000_0004);
        settle;
        chk("path off rail", {31'h0, low_out}, 32'h0);
    endtask

    task automatic t_dual;
        rail_trial(32'h0000_0101, 32'h0000_3014, 16, 1'b1);
        chk("fixed method", {31'h0, low_out}, 32'h0);
        rail_trial(32'h0000_0109, 32'h0000_3014, 2, 1'b1);
        chk("inside hold", {31'h0, low_out}, 32'h0);
        rail_trial(32'h0000_0109, 32'h0000_3014, 16, 1'b0);
        chk("no crossing", {31'h0, low_out}, 32'h0);
        rail_trial(32'h0000_0109, 32'h0000_3014, 16, 1'b1);
        chk("headroom low", {31'h0, low_out}, 32'h1);
        send_word(32'h4000_0000);
        repeat (2) @(posedge i_clock);
        #1;
        chk("loud to high", {31'h0, low_out}, 32'h0);
        rail_trial(32'h0000_0111, 32'h0000_3014, 16, 1'b1);
        chk("lower method", {31'h0, low_out}, 32'h0);
        rail_trial(32'h0000_0109, 32'h0400_3014, 16, 1'b1);
        chk("low rail weak", {31'h0, low_out}, 32'h0);
    endtask

    task automatic t_delay;
        apb(1'b1, amp_rail_pkg::TIMING_OFS, 32'h0000_3014);
        apb(1'b1, amp_rail_pkg::CTRL_OFS, 32'h0000_0101);
        latency;
        chk("dual delay", n, 32'd3);
        apb(1'b1, amp_rail_pkg::CTRL_OFS, 32'h0000_000b);
        latency;
        chk("fixed delay", n, 32'd0);
        chk("path data", o_word, 32'h0c00_0000);
        apb(1'b1, amp_rail_pkg::CTRL_OFS, 32'h0000_000a);
        latency;
        chk("path off", n, 32'd10);
        chk("path off data", o_word, 32'h0);
    endtask

    // Exit bits 8 never below entry bits 4, dual mode, no noise gate in use.
    task automatic t_idle;
        apb(1'b1, amp_rail_pkg::IDLE_OFS, 32'h0000_0804);
        apb(1'b1, amp_rail_pkg::CTRL_OFS, 32'h0000_0049);
        repeat (500) send_word(32'h0001_0000);
        send_word(32'h003f_0000);
        repeat (1024) send_word(32'hffff_0000);
        settle;
        chk("count restart", {31'h0, idle}, 32'h0);
        chk("sense live", {16'h0, o_isense}, 32'h1234);
        send_word(32'h0001_0000);
        settle;
        chk("idle entry", {31'h0, idle}, 32'h1);
        chk("isense zero", {16'h0, o_isense}, 32'h0);
        chk("vsense zero", {16'h0, o_vsense}, 32'h0);
        send_word(32'h0000_ff00);
        send_word(32'h00ff_0000);
        settle;
        chk("below exit", {31'h0, idle}, 32'h1);
        // A 24-bit slot puts eight active bits here, so idle must hold.
        apb(1'b1, amp_rail_pkg::CTRL_OFS, 32'h0000_00c9);
        send_word(32'h0000_ff00);
        settle;
        chk("ws24 below exit", {31'h0, idle}, 32'h1);
        apb(1'b1, amp_rail_pkg::CTRL_OFS, 32'h0000_0149);
        send_word(32'h0000_ff00);
        settle;
        chk("idle exit", {31'h0, idle}, 32'h0);
        chk("vsense back", {16'h0, o_vsense}, 32'h4321);
    endtask

    // ----------------------------------------
    // Clock, guard and main sequence
    // ----------------------------------------
    always #20 i_clock = ~i_clock;

    // Cuts a hang short well beyond the expected run length.
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            tally_and_finish;
        end
    end

    // Holds reset for ten cycles, then runs every scenario in turn.
    initial
    begin
        repeat (10) @(posedge i_clock);
        i_rstn <= 1'b1;
        t_regs;
        t_fixed;
        t_dual;
        t_delay;
        t_idle;
        tally_and_finish;
    end
endmodule
`default_nettype wire
